// ==== design/spicfg_pkg.sv ====
// Package with register map, field positions and reset values of the serial configuration block
package spicfg_pkg;
    localparam logic [7:0] SPICFG_OFS_CTRL2    = 8'h00;
    localparam logic [7:0] SPICFG_OFS_BAUD     = 8'h04;
    localparam logic [7:0] SPICFG_OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] SPICFG_OFS_IRQ_EN   = 8'h0C;
    localparam logic [7:0] SPICFG_OFS_IRQ_CLR  = 8'h10;
    localparam logic [7:0] SPICFG_OFS_CFG      = 8'h14;
    localparam logic [7:0] SPICFG_OFS_MATCH    = 8'h18;
    localparam int SPICFG_CTRL2_MIE  = 7;
    localparam int SPICFG_CTRL2_LEN  = 6;
    localparam int SPICFG_CTRL2_FDE  = 4;
    localparam int SPICFG_CTRL2_SWOE = 3;
    localparam int SPICFG_CTRL2_SIW  = 1;
    localparam int SPICFG_CTRL2_SWS  = 0;
    localparam logic [7:0] SPICFG_CTRL2_MASK  = 8'hDB;
    localparam logic [7:0] SPICFG_CTRL2_RESET = 8'h00;
    localparam logic [7:0] SPICFG_BAUD_MASK   = 8'h77;
    localparam logic [7:0] SPICFG_BAUD_RESET  = 8'h00;
    localparam int SPICFG_PRE_LSB  = 4;
    localparam int SPICFG_RATE_LSB = 0;
    localparam int SPICFG_CFG_MST  = 0;
    localparam int SPICFG_CFG_SSOE = 1;
    localparam int SPICFG_CFG_EN   = 2;
    localparam int SPICFG_IRQ_MATCH = 0;
    localparam int SPICFG_IRQ_ABORT = 1;
    localparam int SPICFG_IRQ_W     = 2;
    localparam logic [1:0] SPICFG_HTRANS_NONSEQ = 2'h2;
endpackage : spicfg_pkg

// ==== design/spicfg_top.sv ====
// Serial configuration block: control two, baud rate, pin mapping, match flag and AHB-Lite slave
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Match flag plus enable raises interrupt
// - Length bit selects 8 or 16 bits
// - Master length change aborts, clears status
// - Slave ignores fault enable; select input
// - Master fault enable frees or uses select
// - Single-wire output enable drives shared pin
// - Output enable ignored when single-wire off
// - Stop-in-wait halts serial clocks in wait
// - Separate pins: master MISO in, MOSI out
// - Master single-wire: MISO freed, MOSI shared
// - Slave single-wire: MOSI freed, MISO shared
// - Baud register accessible at any time
// - Prescaler divides by code plus one
// - Rate divider divides by two^(code+1)
// - Prescaler output feeds rate divider
// - Match flag set on full with equal data
module spicfg_top
    import spicfg_pkg::*;
(
    input  wire logic        hclk,           // Bus clock
    input  wire logic        hresetn,        // Async reset, active low
    input  wire logic        hsel,           // Slave select
    input  wire logic [7:0]  haddr,          // Byte address
    input  wire logic [1:0]  htrans,         // Transfer type
    input  wire logic        hwrite,         // Write strobe
    input  wire logic [2:0]  hsize,          // Transfer size
    input  wire logic [31:0] hwdata,         // Write data
    input  wire logic        hready,         // Bus ready
    output logic [31:0]      hrdata,         // Read data
    output logic             hreadyout,      // Slave ready
    output logic             hresp,          // Always OKAY
    input  wire logic        wait_mode,      // Chip in wait mode
    input  wire logic        rx_full_pulse,  // Receive buffer became full
    input  wire logic [15:0] rx_data,        // Receive buffer contents
    input  wire logic        miso_in,        // MISO pin input
    input  wire logic        mosi_in,        // MOSI pin input
    output logic             miso_out,       // MISO pin output
    output logic             miso_oe_n,      // MISO drive enable, low drives
    output logic             mosi_out,       // MOSI pin output
    output logic             mosi_oe_n,      // MOSI drive enable, low drives
    output logic             miso_spi_owned, // MISO used by the serial unit
    output logic             mosi_spi_owned, // MOSI used by the serial unit
    output logic             ss_spi_owned,   // Select pin used by the serial unit
    output logic             ss_is_output,   // Select pin is automatic output
    output logic             serial_data_in, // Selected serial data input
    input  wire logic        tx_bit,         // Shifter output bit
    output logic             word_16bit,     // Shifter length is 16
    output logic             xfer_abort,     // Abort and status reset; pulse on master length change, held high while disabled
    output logic             baud_tick,      // Serial clock edge enable
    output logic             irq             // Level interrupt
);
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_addr;
    logic [7:0]  ctrl2;
    logic [7:0]  baud;
    logic [2:0]  cfg;
    logic [15:0] match_val;
    logic [SPICFG_IRQ_W-1:0] irq_stat;
    logic [SPICFG_IRQ_W-1:0] irq_en;
    logic        match_flag;
    logic [2:0]  pre_cnt;
    logic [7:0]  rate_cnt;
    logic        pre_tick;
    logic        miso_s1, miso_s2, mosi_s1, mosi_s2;
    logic        len_change;
    logic        wr_ctrl2, wr_clr;
    logic        master, single, swoe, clk_run;
    logic [15:0] rx_cmp;
    logic [15:0] m_cmp;
    logic [7:0]  rate_top;
    logic        wr_baud, wr_irq_en, wr_cfg, wr_match;
    logic [31:0] next_hrdata;

    assign master  = cfg[SPICFG_CFG_MST];
    assign single  = ctrl2[SPICFG_CTRL2_SWS];
    assign swoe    = ctrl2[SPICFG_CTRL2_SWOE] & single;
    assign wr_ctrl2 = ap_valid & ap_write & (ap_addr == SPICFG_OFS_CTRL2);
    assign wr_clr   = ap_valid & ap_write & (ap_addr == SPICFG_OFS_IRQ_CLR);
    assign wr_baud   = ap_valid & ap_write & (ap_addr == SPICFG_OFS_BAUD);
    assign wr_irq_en = ap_valid & ap_write & (ap_addr == SPICFG_OFS_IRQ_EN);
    assign wr_cfg    = ap_valid & ap_write & (ap_addr == SPICFG_OFS_CFG);
    assign wr_match  = ap_valid & ap_write & (ap_addr == SPICFG_OFS_MATCH);
    assign len_change = wr_ctrl2 & master &
                        (hwdata[SPICFG_CTRL2_LEN] != ctrl2[SPICFG_CTRL2_LEN]);
    // Clocks run only when enabled and not parked by wait mode
    assign clk_run = cfg[SPICFG_CFG_EN] & ~(wait_mode & ctrl2[SPICFG_CTRL2_SIW]);
    assign rx_cmp = ctrl2[SPICFG_CTRL2_LEN] ? rx_data : {8'h00, rx_data[7:0]};
    assign m_cmp  = ctrl2[SPICFG_CTRL2_LEN] ? match_val : {8'h00, match_val[7:0]};
    assign rate_top = 8'((16'h0002 << baud[SPICFG_RATE_LSB +: 3]) - 16'h0001);

    // Address phase capture; zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 8'h00;
        end else if (hready) begin
            ap_valid <= hsel & (htrans == SPICFG_HTRANS_NONSEQ);
            ap_write <= hwrite;
            ap_addr  <= haddr;
        end
    end

    // Length bit is writable so the shifter can be sized at run time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl2 <= SPICFG_CTRL2_RESET;
        end else if (wr_ctrl2) begin
            ctrl2 <= hwdata[7:0] & SPICFG_CTRL2_MASK;
        end
    end

    // Baud accepted regardless of transfer state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            baud <= SPICFG_BAUD_RESET;
        end else if (wr_baud) begin
            baud <= hwdata[7:0] & SPICFG_BAUD_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en <= '0;
        end else if (wr_irq_en) begin
            irq_en <= hwdata[SPICFG_IRQ_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= 3'h0;
        end else if (wr_cfg) begin
            cfg <= hwdata[2:0];
        end
    end

    // Full 16 bits kept; the 8-bit compare simply ignores the upper byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_val <= 16'h0000;
        end else if (wr_match) begin
            match_val <= hwdata[15:0];
        end
    end

    // Read mux; only a read address phase loads data, idle cycles return zero
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (hready & hsel & (htrans == SPICFG_HTRANS_NONSEQ) & ~hwrite) begin
            case (haddr)
                SPICFG_OFS_CTRL2:    next_hrdata = {24'h0, ctrl2};
                SPICFG_OFS_BAUD:     next_hrdata = {24'h0, baud};
                SPICFG_OFS_IRQ_STAT: next_hrdata = {30'h0, irq_stat};
                SPICFG_OFS_IRQ_EN:   next_hrdata = {30'h0, irq_en};
                SPICFG_OFS_CFG:      next_hrdata = {29'h0, cfg};
                SPICFG_OFS_MATCH:    next_hrdata = {16'h0, match_val};
                default:             next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    // No wait states ever; kept as flops so outputs come from registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // Match flag; a new match beats a simultaneous clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_flag <= 1'b0;
        end else if (rx_full_pulse && rx_cmp == m_cmp) begin
            match_flag <= 1'b1;
        end else if (len_change || (wr_clr && hwdata[SPICFG_IRQ_MATCH])) begin
            match_flag <= 1'b0;
        end
    end

    // Sticky interrupt status; set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat[SPICFG_IRQ_MATCH] <= match_flag;
            irq_stat[SPICFG_IRQ_ABORT] <= len_change |
                (irq_stat[SPICFG_IRQ_ABORT] & ~(wr_clr & hwdata[SPICFG_IRQ_ABORT]));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            // Match source also needs the control-two enable bit
            irq <= (irq_stat[SPICFG_IRQ_MATCH] & irq_en[SPICFG_IRQ_MATCH] &
                    ctrl2[SPICFG_CTRL2_MIE]) |
                   (irq_stat[SPICFG_IRQ_ABORT] & irq_en[SPICFG_IRQ_ABORT]);
        end
    end

    // Held high while disabled so the shifter stays parked in idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xfer_abort <= 1'b0;
        end else begin
            xfer_abort <= len_change | ~cfg[SPICFG_CFG_EN];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_16bit <= 1'b0;
        end else begin
            word_16bit <= ctrl2[SPICFG_CTRL2_LEN];
        end
    end

    // Prescaler then rate divider; tick marks each serial clock half period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_cnt  <= 3'h0;
            pre_tick <= 1'b0;
        end else if (!clk_run || len_change) begin
            pre_cnt  <= 3'h0;
            pre_tick <= 1'b0;
        end else if (pre_cnt == baud[SPICFG_PRE_LSB +: 3]) begin
            pre_cnt  <= 3'h0;
            pre_tick <= 1'b1;
        end else begin
            pre_cnt  <= pre_cnt + 3'h1;
            pre_tick <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_cnt  <= 8'h00;
            baud_tick <= 1'b0;
        end else if (!clk_run || !master || len_change) begin
            rate_cnt  <= 8'h00;
            baud_tick <= 1'b0;
        end else if (pre_tick) begin
            // One tick per full divide; bus clock over prescale times rate
            baud_tick <= (rate_cnt == rate_top);
            rate_cnt  <= (rate_cnt == rate_top) ? 8'h00 : rate_cnt + 8'h01;
        end else begin
            baud_tick <= 1'b0;
        end
    end

    // Pin synchronisers; pins are asynchronous to the bus clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            miso_s1 <= miso_in;
            miso_s2 <= miso_s1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else begin
            mosi_s1 <= mosi_in;
            mosi_s2 <= mosi_s1;
        end
    end

    // Pin mapping; every pin released to input while in reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            miso_out <= 1'b0;
        end else begin
            miso_out <= master ? 1'b0 : tx_bit;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            miso_oe_n <= 1'b1;
        end else begin
            miso_oe_n <= master ? 1'b1 : (single ? ~swoe : 1'b0);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mosi_out <= 1'b0;
        end else begin
            mosi_out <= master ? tx_bit : 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mosi_oe_n <= 1'b1;
        end else begin
            mosi_oe_n <= master ? (single ? ~swoe : 1'b0) : 1'b1;
        end
    end

    // A freed pin goes back to general-purpose use outside this block
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            miso_spi_owned <= 1'b0;
        end else begin
            miso_spi_owned <= master ? ~single : 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mosi_spi_owned <= 1'b0;
        end else begin
            mosi_spi_owned <= master ? 1'b1 : ~single;
        end
    end

    // Shared pin is read back even while driven, so its own output is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_data_in <= 1'b0;
        end else if (master) begin
            serial_data_in <= single ? mosi_s2 : miso_s2;
        end else begin
            serial_data_in <= single ? miso_s2 : mosi_s2;
        end
    end

    // Select pin function
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ss_spi_owned <= 1'b0;
        end else if (!master) begin
            ss_spi_owned <= 1'b1;
        end else begin
            ss_spi_owned <= ctrl2[SPICFG_CTRL2_FDE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ss_is_output <= 1'b0;
        end else if (!master) begin
            ss_is_output <= 1'b0;
        end else begin
            ss_is_output <= ctrl2[SPICFG_CTRL2_FDE] & cfg[SPICFG_CFG_SSOE];
        end
    end
endmodule // spicfg_top
`default_nettype wire

// ==== verification/spicfg_partner.sv ====
// Far-side serial device model answering on the data pins
`timescale 1ns/1ps
`default_nettype none
module spicfg_partner (
    input  wire logic hclk,      // Bus clock
    input  wire logic miso_out,  // Block MISO data
    input  wire logic miso_oe_n, // Block MISO drive, low drives
    input  wire logic mosi_out,  // Block MOSI data
    input  wire logic mosi_oe_n, // Block MOSI drive, low drives
    output logic      miso_in,   // Resolved MISO level
    output logic      mosi_in    // Resolved MOSI level
);
    logic pat = 1'b0;
    // Toggles every cycle so a stale level never passes for data
    always @(posedge hclk) pat <= ~pat;
    assign miso_in = miso_oe_n ? pat : miso_out;
    assign mosi_in = mosi_oe_n ? ~pat : mosi_out;
endmodule // spicfg_partner
`default_nettype wire

// ==== verification/spicfg_top_properties.sv ====
// Port checker for the serial configuration block
`timescale 1ns/1ps
`default_nettype none
module spicfg_props (
    input wire logic hclk,           // Bus clock
    input wire logic hresetn,        // Async reset
    input wire logic hreadyout,      // Slave ready
    input wire logic hresp,          // Response
    input wire logic mosi_in,        // MOSI input
    input wire logic miso_oe_n,      // MISO drive
    input wire logic mosi_oe_n,      // MOSI drive
    input wire logic miso_spi_owned, // MISO in use
    input wire logic mosi_spi_owned, // MOSI in use
    input wire logic ss_spi_owned,   // Select in use
    input wire logic ss_is_output,   // Select output
    input wire logic serial_data_in, // Data input
    input wire logic xfer_abort,     // Abort
    input wire logic baud_tick       // Clock enable
);
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_ready_always: assert property (hreadyout)
        else $error("wait state seen");
    a_resp_okay: assert property (!hresp)
        else $error("error response seen");
    a_one_driver: assert property (miso_oe_n || mosi_oe_n)
        else $error("both data pins driven");
    a_miso_drive_owned: assert property (!miso_oe_n |-> miso_spi_owned)
        else $error("MISO driven while free");
    a_mosi_drive_owned: assert property (!mosi_oe_n |-> mosi_spi_owned)
        else $error("MOSI driven while free");
    a_ss_out_owned: assert property (ss_is_output |-> ss_spi_owned)
        else $error("select output while free");
    a_tick_gap: assert property (baud_tick |=> !baud_tick)
        else $error("ticks too close");
    a_abort_quiet: assert property (xfer_abort |=> !baud_tick)
        else $error("tick after abort");
    a_shared_input: assert property ((mosi_spi_owned && !miso_spi_owned) [*4]
        |-> serial_data_in == $past(mosi_in, 3))
        else $error("shared pin not used as input");
endmodule // spicfg_props
bind spicfg_top spicfg_props u_props (.*);
`default_nettype wire

// ==== verification/spicfg_top_test.sv ====
// Self-checking bench for the serial configuration block
`timescale 1ns/1ps
`default_nettype none
module spicfg_top_test;
    import spicfg_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, wait_mode;
    logic        rx_full_pulse, miso_in, mosi_in, miso_out, miso_oe_n, mosi_out;
    logic        mosi_oe_n, tx_bit, irq, miso_spi_owned, mosi_spi_owned, ss_spi_owned;
    logic        ss_is_output, serial_data_in, word_16bit, xfer_abort, baud_tick;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [15:0] rx_data;
    int          num_errors, cmp_count, p, t;

    spicfg_top u_dut (.*);
    spicfg_partner u_far (.*);
    assign hready = hreadyout;

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) tx_bit <= ~tx_bit;

    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic hang(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            test_done();
        end
    endtask
    // One single word transfer; read data is taken at the closing edge
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        haddr <= a;
        hwrite <= w;
        htrans <= SPICFG_HTRANS_NONSEQ;
        hsel <= 1'b1;
        n = 0;
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
        hang(n, 50);
        htrans <= 2'h0;
        hwdata <= d;
        n = 0;
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
        hang(n, 50);
        rd = hrdata;
    endtask
    // Idle first so status has settled after the previous write
    task automatic rg(input logic [7:0] a, input logic [31:0] e);
        repeat (2) @(posedge hclk);
        xf(1'b0, a, 32'h0);
        ck(rd, e);
    endtask
    // Skips two ticks so the new setting is in force, then measures
    task automatic tk(output int q);
        repeat (3) begin
            q = 0;
            do @(posedge hclk); while (baud_tick !== 1'b1 && ++q < 3000);
            hang(q, 3000);
        end
    endtask
    task automatic cnt(output int q);
        q = 0;
        repeat (3) @(posedge hclk);
        repeat (40) begin
            @(posedge hclk);
            q += baud_tick;
        end
    endtask
    task automatic px(input logic [15:0] v);
        rx_data <= v;
        rx_full_pulse <= 1'b1;
        @(posedge hclk);
        rx_full_pulse <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask

    initial begin
        {hsel, hwrite, wait_mode, rx_full_pulse, tx_bit, hresetn} = '0;
        haddr = '0;
        htrans = '0;
        hsize = 3'h2;
        hwdata = '0;
        rx_data = '0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rg(SPICFG_OFS_CTRL2, 32'h0);
        rg(SPICFG_OFS_BAUD, 32'h0);
        xf(1'b1, SPICFG_OFS_CTRL2, 32'hFF);
        rg(SPICFG_OFS_CTRL2, 32'hDB);
        xf(1'b1, SPICFG_OFS_BAUD, 32'hFF);
        rg(SPICFG_OFS_BAUD, 32'h77);
        xf(1'b1, 8'h40, 32'hFF);
        rg(8'h40, 32'h0);
        for (int i = 0; i < 32; i++) begin
            xf(1'b1, SPICFG_OFS_CTRL2, 32'(i[3] * 16 + i[2] * 8 + i[1]));
            xf(1'b1, SPICFG_OFS_CFG, 32'(4 + i[4] * 2 + i[0]));
            repeat (6) @(posedge hclk);
            ck({miso_spi_owned, mosi_spi_owned, miso_oe_n, mosi_oe_n, ss_spi_owned,
                ss_is_output}, {!(i[0] & i[1]), !(!i[0] & i[1]), !(!i[0] & (!i[1] | i[2])),
                !(i[0] & (!i[1] | i[2])), !i[0] | i[3], i[0] & i[3] & i[4]});
        end
        xf(1'b1, SPICFG_OFS_CFG, 32'h5);
        xf(1'b1, SPICFG_OFS_CTRL2, 32'h0);
        for (int i = 0; i < 16; i++) begin
            xf(1'b1, SPICFG_OFS_BAUD, 32'(i < 8 ? i * 16 : i - 8));
            tk(p);
            ck(p, i < 8 ? (i + 1) * 2 - 1 : (2 << (i - 8)) - 1);
        end
        wait_mode <= 1'b1;
        xf(1'b1, SPICFG_OFS_BAUD, 32'h0);
        xf(1'b1, SPICFG_OFS_CTRL2, 32'h02);
        cnt(t);
        ck(t, 0);
        xf(1'b1, SPICFG_OFS_CTRL2, 32'h0);
        cnt(t);
        ck(t, 20);
        wait_mode <= 1'b0;
        xf(1'b1, SPICFG_OFS_MATCH, 32'h1234);
        xf(1'b1, SPICFG_OFS_CTRL2, 32'hC0);
        xf(1'b1, SPICFG_OFS_IRQ_EN, 32'h1);
        ck(word_16bit, 1'b1);
        rg(SPICFG_OFS_IRQ_STAT, 32'h2);
        ck(irq, 1'b0);
        px(16'h1234);
        ck(irq, 1'b1);
        rg(SPICFG_OFS_IRQ_STAT, 32'h3);
        xf(1'b1, SPICFG_OFS_IRQ_CLR, 32'h3);
        rg(SPICFG_OFS_IRQ_STAT, 32'h0);
        ck(irq, 1'b0);
        px(16'h1235);
        rg(SPICFG_OFS_IRQ_STAT, 32'h0);
        xf(1'b1, SPICFG_OFS_CTRL2, 32'h80);
        rg(SPICFG_OFS_IRQ_STAT, 32'h2);
        ck(word_16bit, 1'b0);
        px(16'hAB34);
        rg(SPICFG_OFS_IRQ_STAT, 32'h3);
        ck(irq, 1'b1);
        xf(1'b1, SPICFG_OFS_CTRL2, 32'h0);
        rg(SPICFG_OFS_IRQ_STAT, 32'h3);
        ck(irq, 1'b0);
        test_done();
    end
endmodule // spicfg_top_test
`default_nettype wire
